// File: tb/match_based_pwm_timer_tb.sv
/*
  Self-checking testbench of the match-based PWM timer: register tasks and scenario sequences.
  Assumes the register map header and a load model counting pulses on the output pins.
*/
`timescale 1ns/1ps
`include "mbp_map.svh"

`define MBP_CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module match_based_pwm_timer_tb;
  logic              core_clk, resetn, ce, we, re, clr, irq;
  logic [7:0]        addr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        cap_in;
  logic [6:1]        pwm_out;
  logic [6:1][15:0]  hi_cnt, rise_cnt;
  logic [31:0]       m [0:6];
  logic [7:0]        rst_addrs [0:8];
  int                err_total, checks_done;

  mbp_top #(.NM(7)) dut
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .addr     (addr),
    .wdata    (wdata),
    .we       (we),
    .re       (re),
    .rdata    (rdata),
    .cap_in   (cap_in),
    .pwm_out  (pwm_out),
    .irq      (irq)
  );

  mbp_load_model u_load
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (clr),
    .pwm_out  (pwm_out),
    .hi_cnt   (hi_cnt),
    .rise_cnt (rise_cnt)
  );

  always #2 core_clk = ~core_clk;

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycles

  task automatic stop_test();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge core_clk);
    we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] msk,
                        input logic [31:0] exp);
    logic [31:0] d;
    @(posedge core_clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge core_clk);
    re <= 1'b0;
    #1;
    d = rdata & msk;
    `MBP_CHK(nm, exp, d)
  endtask : rd_chk

  task automatic cfg(input logic [31:0] pin);
    wr(`MBP_OFF_CTRL, 32'h0000_0000);
    wr(`MBP_OFF_CTRL, 32'h0000_0002);
    for (int k = 0; k < 7; k++)
      wr(`MBP_OFF_MATCH0 + 8'(4 * k), m[k]);
    wr(`MBP_OFF_PIN, pin);
    wr(`MBP_OFF_CTRL, 32'h0000_0009);
  endtask : cfg

  // Counts over four whole periods, so the result does not depend on the window's phase.
  task automatic measure(input logic [6:0] dbl);
    int p;
    int hi;
    p = int'(m[0]) + 1;
    cycles(2 * p);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    cycles(4 * p);
    #1;
    for (int n = 1; n <= 6; n++)
    begin
      hi = (int'(m[n]) - int'(dbl[n] ? m[n - 1] : m[0]) + p) % p;
      `MBP_CHK("high_cycles", 16'(4 * hi), hi_cnt[n])
      `MBP_CHK("rise_count", (hi == 0) ? 16'h0000 : 16'h0004, rise_cnt[n])
    end
  endtask : measure

  task automatic pulse(input logic [1:0] v);
    cap_in <= v;
    cycles(6);
    cap_in <= 2'b00;
    cycles(6);
  endtask : pulse

  initial
  begin
    cycles(20000);
    err_total++;
    stop_test();
  end

  initial
  begin
    core_clk    = 1'b0;
    resetn      = 1'b0;
    ce          = 1'b1;
    we          = 1'b0;
    re          = 1'b0;
    clr         = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0000_0000;
    cap_in      = 2'b00;
    err_total   = 0;
    checks_done = 0;
    rst_addrs   = '{`MBP_OFF_STS, `MBP_OFF_CTRL, `MBP_OFF_CNT, `MBP_OFF_PRE, `MBP_OFF_MATCH0,
                    `MBP_OFF_PIN, `MBP_OFF_REL, `MBP_OFF_MASK, 8'h80};
    cycles(10);
    `MBP_CHK("pwm_out_in_reset", 6'h00, pwm_out)
    resetn <= 1'b1;
    foreach (rst_addrs[i])
      rd_chk("reset_value", rst_addrs[i], 32'hffff_ffff, 32'h0000_0000);
    wr(`MBP_OFF_CNT, 32'hdead_beef);
    rd_chk("count_rw", `MBP_OFF_CNT, 32'hffff_ffff, 32'hdead_beef);
    wr(8'h80, 32'hffff_ffff);
    rd_chk("unmapped", 8'h80, 32'hffff_ffff, 32'h0000_0000);

    m = '{32'd9, 32'd0, 32'd2, 32'd4, 32'd5, 32'd8, 32'd9};
    cfg(32'h0000_7e00);
    measure(7'h00);

    m = '{32'd9, 32'd2, 32'd6, 32'd7, 32'd3, 32'd0, 32'd9};
    cfg(32'h0000_7e54);
    measure(7'h54);

    wr(`MBP_OFF_MATCH0 + 8'h04, 32'd5);
    measure(7'h54);
    rd_chk("staged_match", `MBP_OFF_MATCH0 + 8'h04, 32'hffff_ffff, 32'd5);
    wr(`MBP_OFF_REL, 32'h0000_0002);
    m[1] = 32'd5;
    measure(7'h54);
    rd_chk("release", `MBP_OFF_REL, 32'h0000_007f, 32'h0000_0000);

    wr(`MBP_OFF_CTRL, 32'h0000_0000);
    wr(`MBP_OFF_STS, 32'h0000_007f);
    wr(`MBP_OFF_CTRL, 32'h0000_0002);
    wr(`MBP_OFF_PRE, 32'h0000_0002);
    wr(`MBP_OFF_MACT, 32'h0000_01c0);
    wr(`MBP_OFF_MATCH0 + 8'h08, 32'd5);
    wr(`MBP_OFF_MASK, 32'h0000_0000);
    wr(`MBP_OFF_CTRL, 32'h0000_0001);
    cycles(8);
    rd_chk("status_early", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0000);
    cycles(20);
    rd_chk("status_hit", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0004);
    rd_chk("stopped", `MBP_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
    rd_chk("count_reset", `MBP_OFF_CNT, 32'hffff_ffff, 32'h0000_0000);
    `MBP_CHK("irq_masked", 1'b0, irq)
    wr(`MBP_OFF_MASK, 32'h0000_0004);
    #1;
    `MBP_CHK("irq_unmasked", 1'b1, irq)
    wr(`MBP_OFF_STS, 32'h0000_0004);
    #1;
    `MBP_CHK("irq_cleared", 1'b0, irq)

    wr(`MBP_OFF_CTRL, 32'h0000_0002);
    wr(`MBP_OFF_PRE, 32'h0000_0000);
    wr(`MBP_OFF_SRC, 32'h0000_0001);
    wr(`MBP_OFF_MATCH0 + 8'h08, 32'd3);
    wr(`MBP_OFF_CTRL, 32'h0000_0001);
    repeat (3) pulse(2'b11);
    cycles(10);
    rd_chk("capture_three", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0000);
    pulse(2'b01);
    cycles(10);
    rd_chk("capture_four", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0004);
    `MBP_CHK("irq_capture", 1'b1, irq)

    // Falling edges, then both edges, of the second capture pin; the first pin must not count.
    for (int s = 6; s <= 7; s++)
    begin
      wr(`MBP_OFF_STS, 32'h0000_0004);
      wr(`MBP_OFF_CTRL, 32'h0000_0002);
      wr(`MBP_OFF_SRC, 32'(s));
      wr(`MBP_OFF_MATCH0 + 8'h08, 32'(2 * s - 11));
      wr(`MBP_OFF_CTRL, 32'h0000_0001);
      pulse(2'b01);
      pulse(2'b10);
      cycles(10);
      rd_chk("capture_sel_early", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0000);
      pulse(2'b10);
      cycles(10);
      rd_chk("capture_sel_hit", `MBP_OFF_STS, 32'h0000_0004, 32'h0000_0004);
    end
    stop_test();
  end
endmodule : match_based_pwm_timer_tb

// File: tb/mbp_load_model.sv
/*
  Load model for the six PWM output pins: counts high cycles and rising edges per pin.
  Assumes pwm_out is registered on core_clk; clr zeroes the counts at the next edge.
*/
`timescale 1ns/1ps

module mbp_load_model
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clr,
  input  wire logic [6:1]        pwm_out,
  output logic      [6:1][15:0]  hi_cnt,
  output logic      [6:1][15:0]  rise_cnt
);
  logic [6:1] prev_r;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hi_cnt   <= '0;
      rise_cnt <= '0;
      prev_r   <= '0;
    end
    else
    begin
      prev_r <= pwm_out;
      for (int n = 1; n <= 6; n++)
      begin
        hi_cnt[n]   <= clr ? 16'h0000 : hi_cnt[n] + {15'h0000, pwm_out[n]};
        rise_cnt[n] <= clr ? 16'h0000 : rise_cnt[n] + {15'h0000, pwm_out[n] & ~prev_r[n]};
      end
    end
  end
endmodule : mbp_load_model

// File: verilog/mbp_chan.sv
/*
  One PWM output channel: single-edge or double-edge set and clear from match hits.
  Assumes hits are one-cycle pulses on counter ticks from the timer core.
*/
`timescale 1ns/1ps

module mbp_chan
  import mbp_pkg::*;
#(
  parameter int IDX = 1
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic ce,
  mbp_match_if.snk  m,
  output logic      pwm_out
);

  logic lvl_r;
  logic lvl_nxt;
  logic out_r;
  logic set_ev;
  logic clr_ev;

  // Double-edge rises on the neighbour below; single-edge rises at cycle start.
  // When rise and fall coincide the fall wins, which gives the constant-low setting.
  always_comb
  begin
    set_ev  = m.dbl[IDX] ? m.hit[IDX-1] : m.hit[0];
    clr_ev  = m.hit[IDX];
    lvl_nxt = clr_ev ? 1'b0 : (set_ev ? 1'b1 : lvl_r);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lvl_r <= 1'b0;
      out_r <= 1'b0;
    end
    else if (ce)
    begin
      lvl_r <= lvl_nxt;
      out_r <= lvl_nxt & m.oe[IDX];
    end
  end

  assign pwm_out = out_r;

  property p_se_fall;
    @(posedge core_clk) disable iff (!resetn)
    ce && !m.dbl[IDX] && m.hit[IDX] |=> !lvl_r;
  endproperty
  a_se_fall: assert property (p_se_fall) else $error("single-edge output did not fall");

  property p_se_rise;
    @(posedge core_clk) disable iff (!resetn)
    ce && !m.dbl[IDX] && m.hit[0] && !m.hit[IDX] |=> lvl_r;
  endproperty
  a_se_rise: assert property (p_se_rise) else $error("single-edge output did not rise");

  property p_de_pulse;
    @(posedge core_clk) disable iff (!resetn)
    ce && m.dbl[IDX] && m.hit[IDX-1] && !m.hit[IDX] |=> lvl_r;
  endproperty
  a_de_pulse: assert property (p_de_pulse) else $error("double-edge output did not rise");

  property p_de_fall;
    @(posedge core_clk) disable iff (!resetn)
    ce && m.dbl[IDX] && m.hit[IDX] |=> !lvl_r;
  endproperty
  a_de_fall: assert property (p_de_fall) else $error("double-edge output did not fall");

endmodule : mbp_chan

// File: verilog/mbp_map.svh
/*
  Register offsets, field positions, reset values and sizes of the match-based PWM timer.
  Assumes byte addresses on an 8-bit register address port with one 32-bit word per register.
*/
`ifndef MBP_MAP_SVH
`define MBP_MAP_SVH

`define MBP_NUM_MATCH  7
`define MBP_NUM_CAP    2
`define MBP_ADDR_W     8
`define MBP_WORD_BYTES 8'h04

`define MBP_OFF_STS    8'h00
`define MBP_OFF_CTRL   8'h04
`define MBP_OFF_CNT    8'h08
`define MBP_OFF_PRE    8'h0c
`define MBP_OFF_PCNT   8'h10
`define MBP_OFF_MACT   8'h14
`define MBP_OFF_MATCH0 8'h18
`define MBP_OFF_SRC    8'h34
`define MBP_OFF_PIN    8'h38
`define MBP_OFF_REL    8'h3c
`define MBP_OFF_MASK   8'h40

`define MBP_CTRL_EN    0
`define MBP_CTRL_RST   1
`define MBP_CTRL_PWM   3
`define MBP_ACT_INT    0
`define MBP_ACT_RST    1
`define MBP_ACT_STOP   2
`define MBP_ACT_W      3
`define MBP_SRC_SEL    2
`define MBP_PIN_OE_LSB 8

`define MBP_RST_WORD   32'h0000_0000
`define MBP_ONE_WORD   32'h0000_0001

`endif

// File: verilog/mbp_match_if.sv
/*
  Carrier from the timer core to the output channels: match hits and pin configuration.
  Assumes one driver, the timer core, and any number of channel readers.
*/
`timescale 1ns/1ps

interface mbp_match_if #(parameter int NM = 7);
  logic [NM-1:0] hit;
  logic [NM-1:0] dbl;
  logic [NM-1:0] oe;

  modport src (output hit, output dbl, output oe);
  modport snk (input hit, input dbl, input oe);
endinterface : mbp_match_if

// File: verilog/mbp_pkg.sv
/*
  Types shared by the match-based PWM timer modules.
  Assumes nothing of its surroundings.
*/
package mbp_pkg;

  typedef enum logic [1:0]
  {
    MBP_SRC_TIMER = 2'b00,
    MBP_SRC_RISE  = 2'b01,
    MBP_SRC_FALL  = 2'b10,
    MBP_SRC_BOTH  = 2'b11
  } mbp_src_t;

endpackage : mbp_pkg

// File: verilog/mbp_sync.sv
/*
  Three-stage input synchroniser with agreement filter for asynchronous pins.
  Assumes inputs asynchronous to core_clk; the output changes only when stages two and three agree.
*/
`timescale 1ns/1ps

module mbp_sync
  import mbp_pkg::*;
#(
  parameter int W = 2
)
(
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  always_comb
  begin
    lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end
    else if (ce)
    begin
      s1_r  <= din;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign dout = lvl_r;

endmodule : mbp_sync

// File: verilog/mbp_top.sv
/*
  Match-based PWM timer: register slave, capture synchroniser, prescaler, 32-bit counter,
  staged and active match values, interrupt status and mask, and the output channels.
  Assumes a single-cycle register master on core_clk and capture pins asynchronous to it.
*/
`timescale 1ns/1ps
`include "mbp_map.svh"

module mbp_top
  import mbp_pkg::*;
#(
  parameter int NM = `MBP_NUM_MATCH
)
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  input  wire logic [`MBP_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   we,
  input  wire logic                   re,
  output logic      [31:0]            rdata,
  input  wire logic [`MBP_NUM_CAP-1:0] cap_in,
  output logic      [NM-1:1]          pwm_out,
  output logic                        irq
);

  mbp_src_t          src_mode_r;
  mbp_src_t          src_mode_nxt;
  logic              src_sel_r;
  logic              src_sel_nxt;
  logic              en_r;
  logic              en_nxt;
  logic              crst_r;
  logic              crst_nxt;
  logic              pwm_r;
  logic              pwm_nxt;
  logic [3*NM-1:0]   mact_r;
  logic [3*NM-1:0]   mact_nxt;
  logic [NM-1:0]     dbl_r;
  logic [NM-1:0]     dbl_nxt;
  logic [NM-1:0]     oe_r;
  logic [NM-1:0]     oe_nxt;
  logic [NM-1:0]     rel_r;
  logic [NM-1:0]     rel_nxt;
  logic [NM-1:0]     sts_r;
  logic [NM-1:0]     sts_nxt;
  logic [NM-1:0]     mask_r;
  logic [NM-1:0]     mask_nxt;
  logic [31:0]       pre_r;
  logic [31:0]       pre_nxt;
  logic [31:0]       pc_r;
  logic [31:0]       pc_nxt;
  logic [31:0]       cnt_r;
  logic [31:0]       cnt_nxt;
  logic [31:0]       stg_r [NM];
  logic [31:0]       stg_nxt [NM];
  logic [31:0]       act_r [NM];
  logic [31:0]       act_nxt [NM];
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [31:0]       rd_val;
  logic [NM*32-1:0]  act_flat;
  logic [`MBP_NUM_CAP-1:0] cap_lvl;
  logic              cap_cur;
  logic              cap_prev_r;
  logic              cap_rise;
  logic              cap_fall;
  logic              cnt_ev;
  logic              run;
  logic              tick;
  logic              start;
  logic              any_rst;
  logic              any_stop;
  logic [NM-1:0]     hit;
  logic [NM-1:0]     hit_int;
  logic [NM-1:0]     hit_rst;
  logic [NM-1:0]     hit_stop;
  logic [NM-1:0]     wr_mr;
  logic              wr_sts;
  logic              wr_ctrl;
  logic              wr_cnt;
  logic              wr_pre;
  logic              wr_pcnt;
  logic              wr_mact;
  logic              wr_src;
  logic              wr_pin;
  logic              wr_rel;
  logic              wr_mask;

  mbp_match_if #(.NM(NM)) mif ();

  mbp_sync #(.W(`MBP_NUM_CAP)) u_sync
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .din      (cap_in),
    .dout     (cap_lvl)
  );

  // Channel n uses match n as its fall and, in double-edge mode, match n-1 as its rise.
  for (genvar n = 1; n < NM; n++)
  begin : g_chan
    mbp_chan #(.IDX(n)) u_chan
    (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ce       (ce),
      .m        (mif.snk),
      .pwm_out  (pwm_out[n])
    );
    assign act_flat[n*32 +: 32] = act_r[n];
  end
  assign act_flat[31:0] = act_r[0];

  assign mif.hit = hit;
  assign mif.dbl = dbl_r;
  assign mif.oe  = oe_r;

  assign wr_sts  = we && (addr == `MBP_OFF_STS);
  assign wr_ctrl = we && (addr == `MBP_OFF_CTRL);
  assign wr_cnt  = we && (addr == `MBP_OFF_CNT);
  assign wr_pre  = we && (addr == `MBP_OFF_PRE);
  assign wr_pcnt = we && (addr == `MBP_OFF_PCNT);
  assign wr_mact = we && (addr == `MBP_OFF_MACT);
  assign wr_src  = we && (addr == `MBP_OFF_SRC);
  assign wr_pin  = we && (addr == `MBP_OFF_PIN);
  assign wr_rel  = we && (addr == `MBP_OFF_REL);
  assign wr_mask = we && (addr == `MBP_OFF_MASK);

  // Count source: every clock in timer mode, or selected capture edges in counter mode.
  assign cap_cur  = cap_lvl[src_sel_r];
  assign cap_rise = cap_cur && !cap_prev_r;
  assign cap_fall = !cap_cur && cap_prev_r;
  assign cnt_ev   = (src_mode_r == MBP_SRC_TIMER) ||
                    (src_mode_r[0] && cap_rise) || (src_mode_r[1] && cap_fall);
  assign run      = en_r && !crst_r;
  assign tick     = run && cnt_ev && (pc_r == pre_r);

  always_comb
  begin
    for (int k = 0; k < NM; k++)
    begin
      hit[k]      = tick && (cnt_r == act_r[k]);
      hit_int[k]  = hit[k] && mact_r[k*`MBP_ACT_W + `MBP_ACT_INT];
      hit_rst[k]  = hit[k] && mact_r[k*`MBP_ACT_W + `MBP_ACT_RST];
      hit_stop[k] = hit[k] && mact_r[k*`MBP_ACT_W + `MBP_ACT_STOP];
      wr_mr[k]    = we && (addr == `MBP_OFF_MATCH0 + 8'(k) * `MBP_WORD_BYTES);
    end
  end

  // In PWM mode the period match always closes the cycle.
  assign start    = pwm_r && hit[0];
  assign any_rst  = (|hit_rst) || start;
  assign any_stop = |hit_stop;

  // Configuration, status and release bits.
  always_comb
  begin
    src_mode_nxt = src_mode_r;
    src_sel_nxt  = src_sel_r;
    en_nxt       = en_r;
    crst_nxt     = crst_r;
    pwm_nxt      = pwm_r;
    mact_nxt     = mact_r;
    dbl_nxt      = dbl_r;
    oe_nxt       = oe_r;
    mask_nxt     = mask_r;
    if (wr_ctrl)
    begin
      en_nxt   = wdata[`MBP_CTRL_EN];
      crst_nxt = wdata[`MBP_CTRL_RST];
      pwm_nxt  = wdata[`MBP_CTRL_PWM];
    end
    if (any_stop)
    begin
      en_nxt = 1'b0;
    end
    if (wr_src)
    begin
      src_mode_nxt = mbp_src_t'(wdata[1:0]);
      src_sel_nxt  = wdata[`MBP_SRC_SEL];
    end
    if (wr_mact)
    begin
      mact_nxt = wdata[3*NM-1:0];
    end
    if (wr_pin)
    begin
      dbl_nxt = wdata[NM-1:0];
      oe_nxt  = wdata[`MBP_PIN_OE_LSB +: NM];
    end
    if (wr_mask)
    begin
      mask_nxt = wdata[NM-1:0];
    end
    // Hardware sets win over a clear in the same cycle.
    sts_nxt = (sts_r & ~(wr_sts ? wdata[NM-1:0] : {NM{1'b0}})) | hit_int;
    rel_nxt = (start ? {NM{1'b0}} : rel_r) | (wr_rel ? wdata[NM-1:0] : {NM{1'b0}});
  end

  // Prescaler and counter.
  always_comb
  begin
    pc_nxt  = pc_r;
    cnt_nxt = cnt_r;
    pre_nxt = wr_pre ? wdata : pre_r;
    if (crst_r)
    begin
      pc_nxt  = `MBP_RST_WORD;
      cnt_nxt = `MBP_RST_WORD;
    end
    else if (run && cnt_ev)
    begin
      pc_nxt = (pc_r == pre_r) ? `MBP_RST_WORD : pc_r + `MBP_ONE_WORD;
      if (tick)
      begin
        cnt_nxt = any_rst ? `MBP_RST_WORD : cnt_r + `MBP_ONE_WORD;
      end
    end
    if (wr_pcnt)
    begin
      pc_nxt = wdata;
    end
    if (wr_cnt)
    begin
      cnt_nxt = wdata;
    end
  end

  // Staged and active match values; PWM mode moves released values over at cycle start.
  always_comb
  begin
    for (int k = 0; k < NM; k++)
    begin
      stg_nxt[k] = wr_mr[k] ? wdata : stg_r[k];
      act_nxt[k] = act_r[k];
      if (!pwm_r && wr_mr[k])
      begin
        act_nxt[k] = wdata;
      end
      else if (start && rel_r[k])
      begin
        act_nxt[k] = stg_r[k];
      end
    end
  end

  // Register read mux; unmapped addresses read zero.
  always_comb
  begin
    rd_val = `MBP_RST_WORD;
    case (addr)
      `MBP_OFF_STS:  rd_val[NM-1:0] = sts_r;
      `MBP_OFF_CTRL:
      begin
        rd_val[`MBP_CTRL_EN]  = en_r;
        rd_val[`MBP_CTRL_RST] = crst_r;
        rd_val[`MBP_CTRL_PWM] = pwm_r;
      end
      `MBP_OFF_CNT:  rd_val = cnt_r;
      `MBP_OFF_PRE:  rd_val = pre_r;
      `MBP_OFF_PCNT: rd_val = pc_r;
      `MBP_OFF_MACT: rd_val[3*NM-1:0] = mact_r;
      `MBP_OFF_SRC:
      begin
        rd_val[1:0]          = src_mode_r;
        rd_val[`MBP_SRC_SEL] = src_sel_r;
      end
      `MBP_OFF_PIN:
      begin
        rd_val[NM-1:0]                = dbl_r;
        rd_val[`MBP_PIN_OE_LSB +: NM] = oe_r;
      end
      `MBP_OFF_REL:  rd_val[NM-1:0] = rel_r;
      `MBP_OFF_MASK: rd_val[NM-1:0] = mask_r;
      default:
      begin
        for (int k = 0; k < NM; k++)
        begin
          if (wr_mr[k] || (addr == `MBP_OFF_MATCH0 + 8'(k) * `MBP_WORD_BYTES))
          begin
            rd_val = stg_r[k];
          end
        end
      end
    endcase
    rdata_nxt = re ? rd_val : `MBP_RST_WORD;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_mode_r <= MBP_SRC_TIMER;
      src_sel_r  <= 1'b0;
      en_r       <= 1'b0;
      crst_r     <= 1'b0;
      pwm_r      <= 1'b0;
      mact_r     <= '0;
      dbl_r      <= '0;
      oe_r       <= '0;
      rel_r      <= '0;
      sts_r      <= '0;
      mask_r     <= '0;
      pre_r      <= `MBP_RST_WORD;
      pc_r       <= `MBP_RST_WORD;
      cnt_r      <= `MBP_RST_WORD;
      cap_prev_r <= 1'b0;
      rdata_r    <= `MBP_RST_WORD;
      for (int k = 0; k < NM; k++)
      begin
        stg_r[k] <= `MBP_RST_WORD;
        act_r[k] <= `MBP_RST_WORD;
      end
    end
    else if (ce)
    begin
      src_mode_r <= src_mode_nxt;
      src_sel_r  <= src_sel_nxt;
      en_r       <= en_nxt;
      crst_r     <= crst_nxt;
      pwm_r      <= pwm_nxt;
      mact_r     <= mact_nxt;
      dbl_r      <= dbl_nxt;
      oe_r       <= oe_nxt;
      rel_r      <= rel_nxt;
      sts_r      <= sts_nxt;
      mask_r     <= mask_nxt;
      pre_r      <= pre_nxt;
      pc_r       <= pc_nxt;
      cnt_r      <= cnt_nxt;
      cap_prev_r <= cap_cur;
      rdata_r    <= rdata_nxt;
      for (int k = 0; k < NM; k++)
      begin
        stg_r[k] <= stg_nxt[k];
        act_r[k] <= act_nxt[k];
      end
    end
  end

  assign rdata = rdata_r;
  assign irq   = |(sts_r & mask_r);

  property p_period_reset;
    @(posedge core_clk) disable iff (!resetn)
    ce && start && !wr_cnt |=> cnt_r == `MBP_RST_WORD;
  endproperty
  a_period_reset: assert property (p_period_reset) else $error("period match kept count");

  property p_tick_step;
    @(posedge core_clk) disable iff (!resetn)
    ce && tick && !any_rst && !wr_cnt |=> cnt_r == $past(cnt_r) + `MBP_ONE_WORD;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("counter did not step on tick");

  property p_hold_between;
    @(posedge core_clk) disable iff (!resetn)
    ce && !tick && !wr_cnt && !crst_r |=> $stable(cnt_r);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("counter moved off tick");

  property p_stop;
    @(posedge core_clk) disable iff (!resetn)
    ce && any_stop |=> !en_r && !tick;
  endproperty
  a_stop: assert property (p_stop) else $error("stop on match ignored");

  property p_irq_set;
    @(posedge core_clk) disable iff (!resetn)
    ce && (hit_int != '0) |=> ((sts_r & $past(hit_int)) == $past(hit_int));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("match interrupt flag lost");

  property p_sync_update;
    @(posedge core_clk) disable iff (!resetn)
    ce && pwm_r && !start |=> $stable(act_flat);
  endproperty
  a_sync_update: assert property (p_sync_update) else $error("match changed mid-cycle");

  property p_release;
    @(posedge core_clk) disable iff (!resetn)
    ce && start && (rel_r == '0) |=> $stable(act_flat);
  endproperty
  a_release: assert property (p_release) else $error("unreleased match applied");

  property p_cap_count;
    @(posedge core_clk) disable iff (!resetn)
    ce && run && (src_mode_r != MBP_SRC_TIMER) && !cnt_ev && !wr_pcnt |=> $stable(pc_r);
  endproperty
  a_cap_count: assert property (p_cap_count) else $error("prescaler moved without edge");

  c_cycle: cover property (@(posedge core_clk) disable iff (!resetn) start ##1 !start);
  c_stop: cover property (@(posedge core_clk) disable iff (!resetn) ce && any_stop);
  c_capture: cover property (@(posedge core_clk) disable iff (!resetn)
                             tick && (src_mode_r != MBP_SRC_TIMER));
  c_irq: cover property (@(posedge core_clk) disable iff (!resetn) $rose(irq));

endmodule : mbp_top
